// ===== hdl/ssw_pkg.sv
`default_nettype none
package ssw_pkg;

	// ==========================================================
	// Bus and memory widths
	localparam int APB_AW = 8;
	localparam int MEM_AW = 16;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DETAIL = 8'h04;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_ERRINFO = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_GROUP = 8'h18;
	localparam logic [7:0] ADDR_INIT = 8'h1c;

	// ==========================================================
	// Control register fields
	localparam int CTRL_W = 4;
	localparam int CTRL_DEFER = 0;
	localparam int CTRL_WR_ADDR_ONLY = 1;
	localparam int CTRL_POSTRESET = 2;
	localparam int CTRL_MAP = 3;
	localparam int CTRL_ABORT = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

	// ==========================================================
	// Alarm channel indices, error detail and fault fields
	localparam int NUM_ALM = 3;
	localparam int ALM_ADDR = 0;
	localparam int ALM_UNCORR = 1;
	localparam int ALM_CORR = 2;
	localparam int DETAIL_PEND = 3;
	localparam int OPERATION_ERROR_BITS_W = 2;
	localparam int OPERATION_ERROR_BITS_DMEM = 0;
	localparam int OPERATION_ERROR_BITS_ADDR = 1;
	localparam int IRQ_W = 4;
	localparam int IRQ_INIT_DONE = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	// ==========================================================
	// Wrapper instances that show the post-reset deviation
	localparam int DMEM_INST_A = 0;
	localparam int DMEM_INST_B = 34;
	localparam int DMEM_INST_C = 35;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic valid;
		logic write;
		logic [MEM_AW-1:0] addr;
		logic corr;
		logic uncorr;
		logic addr_err;
	} ssw_mem_acc_t;

	typedef struct packed {
		logic corr;
		logic uncorr;
		logic addr;
	} ssw_alarm_t;

	typedef enum logic {
		INIT_IDLE,
		INIT_RUN
	} ssw_init_state_t;

endpackage
`default_nettype wire

// ===== hdl/ssw_alarm_chan.sv
`default_nettype none
module ssw_alarm_chan (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Error event and release
	input wire logic err_i,
	input wire logic defer_i,
	input wire logic release_i,
	// Alarm
	output logic alarm_q,
	output logic pending_q
);

	// ==========================================================
	// Alarm pulse and deferred pending state
	// immediate alarm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= (err_i & ~defer_i) | (pending_q & release_i);
		end
	end

	// A new deferred error on the releasing access replaces the one released.
	// held until next access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= (err_i & defer_i) | (pending_q & ~release_i);
		end
	end

	// ==========================================================
	// Checks
	AST_RELEASE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		pending_q && release_i |=> alarm_q)
		else $error("pending alarm not released on access");

endmodule
`default_nettype wire

// ===== hdl/ssw_wrapper.sv
// Operation
// - Correctable ECC error on read raises correctable alarm.
// - Uncorrectable ECC error on read raises uncorrectable alarm.
// - Address fault on read or write raises address alarm.
// - Intended behaviour: alarm issued on the erroneous access itself.
// - Deviation: pending alarm released on next memory or register access.
// - Error status recorded at error time even when alarm is held.
// - Error indication to owning module independent of alarm path.
// - Intended behaviour: application reset sets no alarm or status bit.
// - Deviation: application reset sets data-memory flag in both groups.
// - Deviation: instances 0, 34, 35 set operation error bit zero.
// - Spurious post-reset alarms leave error information at zero.
// - Write-address-only mode: only write address errors are deferred.
// - Cache init on self-test enable change and on mapping change.
// - Mapped caches keep working as caches.
// - Runtime init may be aborted; startup init cannot.
//
// Chosen here: the APB register port and the address map.
`default_nettype none
module ssw_wrapper #(
	parameter int INSTANCE_ID = 0,
	parameter int INIT_DEPTH = 256
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ssw_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory access monitor
	input wire ssw_pkg::ssw_mem_acc_t mem_acc,
	input wire logic app_reset_evt,
	// Self-test enable pin
	input wire logic selftest_en,
	// Alarms and owner indication
	output ssw_pkg::ssw_alarm_t alarm,
	output ssw_pkg::ssw_alarm_t owner_err,
	output logic irq,
	// Cache initialisation
	output logic init_we,
	output logic [$clog2(INIT_DEPTH)-1:0] init_addr,
	output logic cache_mapped
);

	localparam int IAW = $clog2(INIT_DEPTH);
	localparam logic [IAW-1:0] INIT_LAST = IAW'(INIT_DEPTH - 1);
	localparam bit AFFECTED = (INSTANCE_ID == ssw_pkg::DMEM_INST_A) ||
		(INSTANCE_ID == ssw_pkg::DMEM_INST_B) || (INSTANCE_ID == ssw_pkg::DMEM_INST_C);

	generate
		if (INIT_DEPTH < 2) begin : g_bad_depth
			$error("INIT_DEPTH must be at least 2");
		end
	endgenerate

	// ==========================================================
	// APB access decode
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic setup;
	logic acc_done;
	logic wr_en;
	logic addr_ok;
	logic [ssw_pkg::CTRL_W-1:0] ctrl_q;
	logic [ssw_pkg::NUM_ALM-1:0] detail_q;
	logic detail_pend;
	logic [ssw_pkg::OPERATION_ERROR_BITS_W-1:0] fault_q;
	logic [ssw_pkg::MEM_AW+1:0] errinfo_q;
	logic [ssw_pkg::IRQ_W-1:0] irq_stat_q;
	logic [ssw_pkg::IRQ_W-1:0] irq_mask_q;
	logic [1:0] grp_q;
	logic startup_q;
	ssw_pkg::ssw_init_state_t init_state_q;

	assign setup = psel & ~penable;
	assign acc_done = psel & penable & pready_q;
	assign wr_en = acc_done & pwrite;

	always_comb begin
		unique case (paddr)
			ssw_pkg::ADDR_CTRL, ssw_pkg::ADDR_DETAIL, ssw_pkg::ADDR_FAULT,
			ssw_pkg::ADDR_ERRINFO, ssw_pkg::ADDR_IRQ_STAT, ssw_pkg::ADDR_IRQ_MASK,
			ssw_pkg::ADDR_GROUP, ssw_pkg::ADDR_INIT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Answer is prepared in the setup cycle so pready rises with the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~addr_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			unique case (paddr)
				ssw_pkg::ADDR_CTRL: prdata_q <= 32'(ctrl_q);
				ssw_pkg::ADDR_DETAIL: prdata_q <= 32'({detail_pend, detail_q});
				ssw_pkg::ADDR_FAULT: prdata_q <= 32'(fault_q);
				ssw_pkg::ADDR_ERRINFO: prdata_q <= 32'(errinfo_q);
				ssw_pkg::ADDR_IRQ_STAT: prdata_q <= 32'(irq_stat_q);
				ssw_pkg::ADDR_IRQ_MASK: prdata_q <= 32'(irq_mask_q);
				ssw_pkg::ADDR_GROUP: prdata_q <= 32'(grp_q);
				ssw_pkg::ADDR_INIT: prdata_q <= 32'({startup_q, init_state_q == ssw_pkg::INIT_RUN});
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ==========================================================
	// Control register
	logic wr_ctrl;
	logic map_chg;
	logic abort_req;

	assign wr_ctrl = wr_en && paddr == ssw_pkg::ADDR_CTRL;
	assign map_chg = wr_ctrl && pwdata[ssw_pkg::CTRL_MAP] != ctrl_q[ssw_pkg::CTRL_MAP];
	assign abort_req = wr_ctrl & pwdata[ssw_pkg::CTRL_ABORT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ssw_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[ssw_pkg::CTRL_W-1:0];
		end
	end

	assign cache_mapped = ctrl_q[ssw_pkg::CTRL_MAP];

	// ==========================================================
	// Error events and alarm channels
	logic mem_rd;
	logic [ssw_pkg::NUM_ALM-1:0] err_ev;
	logic [ssw_pkg::NUM_ALM-1:0] defer;
	logic [ssw_pkg::NUM_ALM-1:0] pend;
	logic [ssw_pkg::NUM_ALM-1:0] alm;
	logic release_acc;
	logic reg_acc;

	assign mem_rd = mem_acc.valid & ~mem_acc.write;
	assign err_ev[ssw_pkg::ALM_CORR] = mem_rd & mem_acc.corr;
	assign err_ev[ssw_pkg::ALM_UNCORR] = mem_rd & mem_acc.uncorr;
	assign err_ev[ssw_pkg::ALM_ADDR] = mem_acc.valid & mem_acc.addr_err;

	assign reg_acc = acc_done & addr_ok;
	assign release_acc = mem_acc.valid | reg_acc;

	generate
		for (genvar i = 0; i < ssw_pkg::NUM_ALM; i++) begin : g_alm
			assign defer[i] = ctrl_q[ssw_pkg::CTRL_DEFER] &
				(~ctrl_q[ssw_pkg::CTRL_WR_ADDR_ONLY] |
				(i == ssw_pkg::ALM_ADDR && mem_acc.write));
			ssw_alarm_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.err_i(err_ev[i]),
				.defer_i(defer[i]),
				.release_i(release_acc),
				.alarm_q(alm[i]),
				.pending_q(pend[i])
			);
		end
	endgenerate

	assign alarm = ssw_pkg::ssw_alarm_t'(alm);

	// ==========================================================
	// Owner indication, never gated by deferral
	logic [ssw_pkg::NUM_ALM-1:0] owner_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			owner_q <= '0;
		end else begin
			owner_q <= err_ev;
		end
	end

	assign owner_err = ssw_pkg::ssw_alarm_t'(owner_q);

	// ==========================================================
	// Status registers, write one to clear (error information: any write clears), set wins
	logic wr_detail;
	logic wr_fault;
	logic wr_grp;
	logic spurious;

	assign wr_detail = wr_en && paddr == ssw_pkg::ADDR_DETAIL;
	assign wr_fault = wr_en && paddr == ssw_pkg::ADDR_FAULT;
	assign wr_grp = wr_en && paddr == ssw_pkg::ADDR_GROUP;
	assign spurious = app_reset_evt & ctrl_q[ssw_pkg::CTRL_POSTRESET] & AFFECTED;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detail_q[ssw_pkg::NUM_ALM-1:0] <= '0;
		end else begin
			detail_q[ssw_pkg::NUM_ALM-1:0] <= err_ev |
				(detail_q[ssw_pkg::NUM_ALM-1:0] & ~(wr_detail ?
				pwdata[ssw_pkg::NUM_ALM-1:0] : '0));
		end
	end

	// The pending summary sits just above the sticky bits when the register is read.
	assign detail_pend = |pend;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= '0;
		end else begin
			fault_q[ssw_pkg::OPERATION_ERROR_BITS_DMEM] <= err_ev[ssw_pkg::ALM_UNCORR] | spurious |
				(fault_q[ssw_pkg::OPERATION_ERROR_BITS_DMEM] & ~(wr_fault & pwdata[ssw_pkg::OPERATION_ERROR_BITS_DMEM]));
			fault_q[ssw_pkg::OPERATION_ERROR_BITS_ADDR] <= err_ev[ssw_pkg::ALM_ADDR] |
				(fault_q[ssw_pkg::OPERATION_ERROR_BITS_ADDR] & ~(wr_fault & pwdata[ssw_pkg::OPERATION_ERROR_BITS_ADDR]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_q <= 2'h0;
		end else begin
			grp_q <= {2{spurious | err_ev[ssw_pkg::ALM_UNCORR]}} |
				(grp_q & ~(wr_grp ? pwdata[1:0] : 2'h0));
		end
	end

	// Only genuine errors load the information word, so a post-reset flag with
	// a zero word can be told apart from a real fault.
	// spurious leaves zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			errinfo_q <= '0;
		end else if (|err_ev) begin
			errinfo_q <= {1'b1, mem_acc.write, mem_acc.addr};
		end else if (wr_en && paddr == ssw_pkg::ADDR_ERRINFO) begin
			errinfo_q <= '0;
		end
	end

	// ==========================================================
	// Cache initialisation engine
	logic st_s1_q;
	logic st_s2_q;
	logic st_s3_q;
	logic init_trig;
	logic init_done;
	logic [IAW-1:0] init_addr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_s1_q <= 1'b0;
			st_s2_q <= 1'b0;
			st_s3_q <= 1'b0;
		end else begin
			st_s1_q <= selftest_en;
			st_s2_q <= st_s1_q;
			st_s3_q <= st_s2_q;
		end
	end

	assign init_trig = (st_s2_q ^ st_s3_q) | map_chg;
	assign init_done = init_state_q == ssw_pkg::INIT_RUN && init_addr_q == INIT_LAST;

	// Startup init runs from reset release and ignores abort.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_state_q <= ssw_pkg::INIT_RUN;
			startup_q <= 1'b1;
			init_addr_q <= '0;
		end else begin
			unique case (init_state_q)
				ssw_pkg::INIT_IDLE: begin
					init_addr_q <= '0;
					if (init_trig) begin
						init_state_q <= ssw_pkg::INIT_RUN;
					end
				end
				ssw_pkg::INIT_RUN: begin
					init_addr_q <= init_addr_q + 1'b1;
					if (abort_req && !startup_q) begin
						init_state_q <= ssw_pkg::INIT_IDLE;
						init_addr_q <= '0;
					end else if (init_trig) begin
						init_addr_q <= '0;
					end else if (init_done) begin
						init_state_q <= ssw_pkg::INIT_IDLE;
						startup_q <= 1'b0;
					end
				end
			endcase
		end
	end

	assign init_we = init_state_q == ssw_pkg::INIT_RUN;
	assign init_addr = init_addr_q;

	// ==========================================================
	// Interrupt status, mask and output
	logic [ssw_pkg::IRQ_W-1:0] irq_ev;
	logic irq_q;

	assign irq_ev = {init_done & ~init_trig, err_ev};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_ev | (irq_stat_q & ~((wr_en && paddr == ssw_pkg::ADDR_IRQ_STAT) ?
				pwdata[ssw_pkg::IRQ_W-1:0] : '0));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= ssw_pkg::IRQ_MASK_RESET;
		end else if (wr_en && paddr == ssw_pkg::ADDR_IRQ_MASK) begin
			irq_mask_q <= pwdata[ssw_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign irq = irq_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_CORR_IMMEDIATE: assert property (
		err_ev[ssw_pkg::ALM_CORR] && !ctrl_q[ssw_pkg::CTRL_DEFER] |=> alarm.corr)
		else $error("correctable alarm missing");
	AST_UNCORR_ALARM: assert property (
		err_ev[ssw_pkg::ALM_UNCORR] && !defer[ssw_pkg::ALM_UNCORR] |=> alarm.uncorr)
		else $error("uncorrectable alarm missing");
	AST_ADDR_WRITE: assert property (
		mem_acc.valid && mem_acc.write && mem_acc.addr_err && !ctrl_q[ssw_pkg::CTRL_DEFER]
		|=> alarm.addr)
		else $error("address alarm missing on write");
	AST_DEFER_HOLD: assert property (
		err_ev[ssw_pkg::ALM_CORR] && defer[ssw_pkg::ALM_CORR] && !pend[ssw_pkg::ALM_CORR]
		##1 !release_acc |=> !alarm.corr)
		else $error("deferred alarm leaked without access");
	AST_DETAIL_RECORD: assert property (
		err_ev[ssw_pkg::ALM_UNCORR] |=> detail_q[ssw_pkg::ALM_UNCORR] &&
		fault_q[ssw_pkg::OPERATION_ERROR_BITS_DMEM])
		else $error("error status not recorded");
	AST_OWNER_INDEP: assert property (
		err_ev[ssw_pkg::ALM_UNCORR] |=> owner_err.uncorr)
		else $error("owner indication gated");
	AST_NO_RESET_STATUS: assert property (
		app_reset_evt && !ctrl_q[ssw_pkg::CTRL_POSTRESET] && !mem_acc.valid && !wr_en
		|=> $stable(grp_q) && $stable(fault_q))
		else $error("application reset changed status");
	AST_POSTRESET_FLAGS: assert property (
		spurious |=> grp_q == 2'h3 && fault_q[ssw_pkg::OPERATION_ERROR_BITS_DMEM])
		else $error("post-reset flags not set");
	AST_ERRINFO_ZERO: assert property (
		spurious && errinfo_q == '0 && err_ev == '0 |=> errinfo_q == '0)
		else $error("error information changed by spurious alarm");
	AST_WR_ADDR_ONLY: assert property (
		ctrl_q[ssw_pkg::CTRL_WR_ADDR_ONLY] && err_ev[ssw_pkg::ALM_UNCORR] |=> alarm.uncorr)
		else $error("read error deferred in write-address-only mode");
	AST_INIT_ON_MAP: assert property (
		map_chg |=> init_we && init_addr == '0)
		else $error("mapping change did not start init");
	AST_STARTUP_NO_ABORT: assert property (
		startup_q && init_we && abort_req && !init_done |=> init_we)
		else $error("startup init aborted");

	COV_DEFERRED_RELEASE: cover property (
		pend[ssw_pkg::ALM_ADDR] && release_acc ##1 alarm.addr);
	COV_POSTRESET: cover property (spurious);
	COV_RUNTIME_ABORT: cover property (init_we && !startup_q && abort_req ##1 !init_we);
	COV_IRQ: cover property (irq);

endmodule
`default_nettype wire

// ===== verification/ssw_sm_model.sv
`default_nettype none
module ssw_sm_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Alarms from the wrapper
	input wire ssw_pkg::ssw_alarm_t alarm
);
	timeunit 1ns;
	timeprecision 1ps;

	int n_corr = 0;
	int n_unc = 0;
	int n_addr = 0;
	int n_long = 0;
	ssw_pkg::ssw_alarm_t prev = '0;

	// ==========================================================
	// Alarm collection
	// one count per cycle the alarm is high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= '0;
		end else begin
			if (alarm.corr) n_corr <= n_corr + 1;
			if (alarm.uncorr) n_unc <= n_unc + 1;
			if (alarm.addr) n_addr <= n_addr + 1;
			// A level held over two edges would hide a second error, so it is counted apart.
			if ((alarm & prev) != 3'h0) n_long <= n_long + 1;
			prev <= alarm;
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 16;

	// ==========================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ssw_pkg::ssw_mem_acc_t mem_acc = '0;
	logic app_reset_evt = 1'b0;
	logic selftest_en = 1'b0;
	ssw_pkg::ssw_alarm_t alarm;
	ssw_pkg::ssw_alarm_t owner_err;
	ssw_pkg::ssw_alarm_t al;
	ssw_pkg::ssw_alarm_t ow;
	logic irq;
	logic init_we;
	logic [$clog2(DEPTH)-1:0] init_addr;
	logic cache_mapped;
	logic [31:0] rd;
	logic err;
	int error_cnt = 0;
	int n_checks = 0;
	int cycles = 0;

	always #12.5 pclk = ~pclk;

	ssw_wrapper #(.INSTANCE_ID(0), .INIT_DEPTH(DEPTH)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_acc(mem_acc), .app_reset_evt(app_reset_evt), .selftest_en(selftest_en),
		.alarm(alarm), .owner_err(owner_err), .irq(irq), .init_we(init_we),
		.init_addr(init_addr), .cache_mapped(cache_mapped)
	);

	ssw_sm_model sm (.pclk(pclk), .presetn(presetn), .alarm(alarm));

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// The request is held until the edge at which pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic mem_go(input logic w, input logic [15:0] a, input logic [2:0] f);
		@(posedge pclk);
		mem_acc <= '{valid: 1'b1, write: w, addr: a, corr: f[2], uncorr: f[1], addr_err: f[0]};
		@(posedge pclk);
		mem_acc <= '0;
		#1;
		al = alarm;
		ow = owner_err;
	endtask

	task automatic clear_all();
		wr(ssw_pkg::ADDR_DETAIL, 32'h7);
		wr(ssw_pkg::ADDR_FAULT, 32'h3);
		wr(ssw_pkg::ADDR_GROUP, 32'h3);
		wr(ssw_pkg::ADDR_IRQ_STAT, 32'hf);
		wr(ssw_pkg::ADDR_ERRINFO, 32'h0);
	endtask

	task automatic count_init(output int n);
		n = 0;
		repeat (40) begin
			if (init_we === 1'b1) n++;
			tick(1);
		end
	endtask

	task automatic app_pulse();
		@(posedge pclk);
		app_reset_evt <= 1'b1;
		@(posedge pclk);
		app_reset_evt <= 1'b0;
		tick(2);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] za [6] = '{ssw_pkg::ADDR_CTRL, ssw_pkg::ADDR_DETAIL, ssw_pkg::ADDR_FAULT,
			ssw_pkg::ADDR_ERRINFO, ssw_pkg::ADDR_IRQ_MASK, ssw_pkg::ADDR_GROUP};
		int n;
		count_init(n);
		check("startup init done", {31'h0, init_we}, 32'h0);
		foreach (za[i]) rdchk(za[i], 32'h0, "reset value");
		apb(1'b0, 8'hf0, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_direct();
		logic [3:0] tbl [4] = '{4'b0100, 4'b0010, 4'b1001, 4'b1100};
		logic [2:0] e;
		clear_all();
		for (int i = 0; i < 4; i++) begin
			mem_go(tbl[i][3], 16'h0100 + 16'(i), tbl[i][2:0]);
			e = tbl[i][3] ? {2'b00, tbl[i][0]} : tbl[i][2:0];
			check("alarm now", {29'h0, al}, {29'h0, e});
			check("owner now", {29'h0, ow}, {29'h0, e});
		end
		rdchk(ssw_pkg::ADDR_DETAIL, 32'h7, "detail");
		rdchk(ssw_pkg::ADDR_ERRINFO, 32'h30102, "errinfo");
		rdchk(ssw_pkg::ADDR_FAULT, 32'h3, "fault");
		check("corr count", n_of(0), 32'h1);
		check("unc count", n_of(1), 32'h1);
		check("addr count", n_of(2), 32'h1);
		clear_all();
		rdchk(ssw_pkg::ADDR_DETAIL, 32'h0, "detail cleared");
		$display("test direct done");
	endtask

	function automatic logic [31:0] n_of(input int k);
		return (k == 0) ? sm.n_corr : (k == 1) ? sm.n_unc : sm.n_addr;
	endfunction

	task automatic t_defer();
		wr(ssw_pkg::ADDR_CTRL, 32'h1);
		mem_go(1'b0, 16'h0040, 3'b010);
		check("held alarm", {29'h0, al}, 32'h0);
		check("owner undeferred", {29'h0, ow}, 32'h2);
		rdchk(ssw_pkg::ADDR_DETAIL, 32'ha, "detail pending");
		tick(2);
		check("released unc", n_of(1), 32'h2);
		rdchk(ssw_pkg::ADDR_DETAIL, 32'h2, "pending gone");
		mem_go(1'b0, 16'h0041, 3'b100);
		check("held corr", {29'h0, al}, 32'h0);
		// dummy read releases the held alarm
		mem_go(1'b0, 16'h0042, 3'b000);
		check("release on access", {29'h0, al}, 32'h4);
		clear_all();
		$display("test defer done");
	endtask

	task automatic t_wronly();
		wr(ssw_pkg::ADDR_CTRL, 32'h3);
		mem_go(1'b1, 16'h0050, 3'b001);
		check("write addr held", {29'h0, al}, 32'h0);
		mem_go(1'b0, 16'h0050, 3'b100);
		check("read releases", {29'h0, al}, 32'h5);
		clear_all();
		$display("test write only done");
	endtask

	task automatic t_app();
		wr(ssw_pkg::ADDR_CTRL, 32'h0);
		app_pulse();
		rdchk(ssw_pkg::ADDR_GROUP, 32'h0, "group clean");
		rdchk(ssw_pkg::ADDR_FAULT, 32'h0, "fault clean");
		wr(ssw_pkg::ADDR_CTRL, 32'h4);
		app_pulse();
		rdchk(ssw_pkg::ADDR_GROUP, 32'h3, "group flags");
		rdchk(ssw_pkg::ADDR_FAULT, 32'h1, "op error");
		// software clears only when error information is zero
		rdchk(ssw_pkg::ADDR_ERRINFO, 32'h0, "errinfo zero");
		check("no alarm", n_of(1), 32'h2);
		wr(ssw_pkg::ADDR_GROUP, 32'h3);
		wr(ssw_pkg::ADDR_FAULT, 32'h1);
		rdchk(ssw_pkg::ADDR_GROUP, 32'h0, "group cleared");
		wr(ssw_pkg::ADDR_CTRL, 32'h0);
		$display("test app reset done");
	endtask

	task automatic t_irq();
		clear_all();
		wr(ssw_pkg::ADDR_IRQ_MASK, 32'h4);
		mem_go(1'b0, 16'h0060, 3'b100);
		tick(1);
		check("irq raised", {31'h0, irq}, 32'h1);
		rdchk(ssw_pkg::ADDR_IRQ_STAT, 32'h4, "irq stat");
		wr(ssw_pkg::ADDR_IRQ_MASK, 32'h0);
		tick(1);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(ssw_pkg::ADDR_IRQ_MASK, 32'h4);
		wr(ssw_pkg::ADDR_IRQ_STAT, 32'h4);
		tick(1);
		check("irq cleared", {31'h0, irq}, 32'h0);
		clear_all();
		$display("test irq done");
	endtask

	task automatic t_init();
		int n;
		wr(ssw_pkg::ADDR_CTRL, 32'h8);
		check("mapped", {31'h0, cache_mapped}, 32'h1);
		check("init start addr", 32'(init_addr), 32'h0);
		count_init(n);
		check("map init len", n, DEPTH);
		rdchk(ssw_pkg::ADDR_IRQ_STAT, 32'h8, "init done");
		@(posedge pclk);
		selftest_en <= 1'b1;
		count_init(n);
		check("selftest init len", n, DEPTH);
		wr(ssw_pkg::ADDR_CTRL, 32'h0);
		wr(ssw_pkg::ADDR_CTRL, 32'h10);
		tick(2);
		check("aborted", {31'h0, init_we}, 32'h0);
		rdchk(ssw_pkg::ADDR_INIT, 32'h0, "init idle");
		$display("test init done");
	endtask

	// ==========================================================
	// Run control
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_direct();
		t_defer();
		t_wronly();
		t_app();
		t_irq();
		t_init();
		check("pulse width", sm.n_long, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
